// *** core/gated_sixteen_bit_timer.sv ***
// gated sixteen-bit timer with prescaler and classic wishbone registers
`timescale 1ns/1ns
`default_nettype none
`include "timer_defines.svh"
module gated_sixteen_bit_timer (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        ext_clk_i,
	input  wire logic        crystal_input_pin_i,
	input  wire logic        gate_pin_i,
	input  wire logic        companion_overflow_i,
	input  wire logic        comparator_i,
	input  wire logic        sleep_i,
	output logic             low_power_osc_enable_o,
	output logic             irq_o,
	output logic             wake_o
);
	timer_pkg::byte_t     counter_control;
	timer_pkg::byte_t     gate_control;
	timer_pkg::count_t    count;
	logic [2:0]           psc;
	logic                 count_overflow_flag;
	logic                 ovf_mask;
	logic                 gate_sig;
	logic                 gate_ok;
	logic                 sleep_ok;
	logic                 count_step;
	logic                 req;
	logic                 wr;
	logic                 wr_lo;
	logic                 wr_hi;
	logic                 count_write;
	logic                 ovf_event;
	logic                 psc_adv;
	logic                 stat_clear;
	logic                 next_irq;
	logic [31:0]          next_dat;

	logic                 counter_run_enable;
	logic                 sync_bypass;
	logic                 clock_source_ext;
	timer_pkg::prescale_t clock_prescale_select;
	logic                 gate_function_enable;
	logic                 gate_level_polarity;
	timer_pkg::gate_src_t gate_source_select;

	clk_edge_if edge_bus ();

	clk_front_end front (
		.clk_i               (clk_i),
		.rst_i               (rst_i),
		.ext_clk_i           (ext_clk_i),
		.crystal_input_pin_i (crystal_input_pin_i),
		.edge_bus            (edge_bus)
	);

	// terminal count of the prescaler for a select value
	function automatic logic [2:0] psc_last(input timer_pkg::prescale_t sel);
		logic [2:0] t;
		case (sel)
			2'h0:    t = 3'h0;
			2'h1:    t = 3'h1;
			2'h2:    t = 3'h3;
			default: t = 3'h7;
		endcase
		return t;
	endfunction

	// field extraction
	assign counter_run_enable    = counter_control[`CTRL_RUN];
	assign sync_bypass           = counter_control[`CTRL_SYNC_BYP];
	assign clock_source_ext      = counter_control[`CTRL_SRC_BIT];
	assign clock_prescale_select = counter_control[`CTRL_PSC_LSB +: 2];
	assign gate_function_enable  = gate_control[`GATE_EN];
	assign gate_level_polarity   = gate_control[`GATE_POL];
	assign gate_source_select    = gate_control[`GATE_SRC_LSB +: 2];

	assign edge_bus.ext_sel = clock_source_ext;
	assign edge_bus.osc_sel = counter_control[`CTRL_OSC_EN];
	assign edge_bus.bypass  = sync_bypass;

	// gate source mux, reserved code keeps gate low
	always_comb begin
		case (gate_source_select)
			`GSRC_PIN:       gate_sig = gate_pin_i;
			`GSRC_COMPANION: gate_sig = companion_overflow_i;
			`GSRC_COMPARE:   gate_sig = comparator_i;
			default:         gate_sig = 1'b0;
		endcase
	end

	assign gate_ok = !gate_function_enable || (gate_sig == gate_level_polarity);

	// only the unsynchronised external path survives sleep
	assign sleep_ok = !sleep_i || (clock_source_ext && sync_bypass);

	// count on selected rising edge once prescaler wraps
	assign psc_adv    = counter_run_enable && gate_ok && sleep_ok && edge_bus.tick;
	assign count_step = psc_adv && (psc == psc_last(clock_prescale_select));

	// bus decode; a request is served in the cycle before ack
	assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr    = req && wb_we_i && wb_sel_i[0];
	assign wr_lo = wr && (wb_adr_i == `ADR_CNT_LO);
	assign wr_hi = wr && (wb_adr_i == `ADR_CNT_HI);
	assign count_write = wr_lo || wr_hi;
	// a step lost to a count write is no wrap, so it must not raise the flag
	assign ovf_event   = count_step && !count_write && (count == `COUNT_MAX);
	assign stat_clear  = wr && (wb_adr_i == `ADR_IRQ_STAT) && wb_dat_i[`IRQ_OVF];

	// control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			counter_control <= `CTRL_RESET;
			gate_control    <= `GATE_RESET;
			ovf_mask        <= 1'b0;
		end else if (wr) begin
			if (wb_adr_i == `ADR_CTRL) begin
				counter_control <= wb_dat_i[7:0];
			end
			if (wb_adr_i == `ADR_GATE) begin
				gate_control <= wb_dat_i[7:0];
			end
			if (wb_adr_i == `ADR_IRQ_MASK) begin
				ovf_mask <= wb_dat_i[`IRQ_OVF];
			end
		end
	end

	// prescale counter divides the selected edges
	// any count byte write clears it
	always_ff @(posedge clk_i) begin
		if (rst_i || count_write) begin
			psc <= 3'h0;
		end else if (psc_adv) begin
			if (psc == psc_last(clock_prescale_select)) begin
				psc <= 3'h0;
			end else begin
				psc <= psc + 3'h1;
			end
		end
	end

	// count holds unless stepped; a write overrides a step
	// software writes one byte at a time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count <= `COUNT_RESET;
		end else if (wr_lo) begin
			count[7:0] <= wb_dat_i[7:0];
		end else if (wr_hi) begin
			count[15:8] <= wb_dat_i[7:0];
		end else if (count_step) begin
			count <= count + 16'h0001;
		end
	end

	// sticky flag, set wins over a write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_overflow_flag <= 1'b0;
		end else if (ovf_event) begin
			count_overflow_flag <= 1'b1;
		end else if (stat_clear) begin
			count_overflow_flag <= 1'b0;
		end
	end

	// oscillator enable follows its bit, ignores sleep
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_power_osc_enable_o <= 1'b0;
		end else begin
			low_power_osc_enable_o <= counter_control[`CTRL_OSC_EN];
		end
	end

	// level interrupt, doubles as wake while sleeping
	assign next_irq = (count_overflow_flag || ovf_event) && ovf_mask;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o  <= 1'b0;
			wake_o <= 1'b0;
		end else begin
			irq_o  <= next_irq;
			wake_o <= next_irq && sleep_i;
		end
	end

	// single domain, so a byte read is never torn
	// the two bytes are separate reads
	always_comb begin
		next_dat = 32'h0000_0000;
		case (wb_adr_i)
			`ADR_CTRL:     next_dat[7:0] = counter_control;
			`ADR_GATE:     next_dat[7:0] = {gate_control[7:3], gate_sig, gate_control[1:0]};
			`ADR_CNT_LO:   next_dat[7:0] = count[7:0];
			`ADR_CNT_HI:   next_dat[7:0] = count[15:8];
			`ADR_IRQ_STAT: next_dat[`IRQ_OVF] = count_overflow_flag;
			`ADR_IRQ_MASK: next_dat[`IRQ_OVF] = ovf_mask;
			default:       next_dat = 32'h0000_0000;
		endcase
	end

	// one wait-free answer; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? next_dat : 32'h0000_0000;
		end
	end

	property p_step_inc;
		@(posedge clk_i) disable iff (rst_i)
		count_step && !count_write |=> count == $past(count) + 16'h0001;
	endproperty
	a_step_inc: assert property (p_step_inc) else $error("step did not add one");

	// divide by eight needs eight edges
	property p_div8;
		@(posedge clk_i) disable iff (rst_i)
		count_step && clock_prescale_select == 2'h3 && $past(psc_adv) |-> $past(psc) == 3'h6;
	endproperty
	a_div8: assert property (p_div8) else $error("divide by eight wrong");

	property p_psc_clear;
		@(posedge clk_i) disable iff (rst_i)
		count_write |=> psc == 3'h0;
	endproperty
	a_psc_clear: assert property (p_psc_clear) else $error("prescaler not cleared");

	property p_osc_sleep;
		@(posedge clk_i) disable iff (rst_i)
		sleep_i && counter_control[`CTRL_OSC_EN] ##1 counter_control[`CTRL_OSC_EN]
		|-> low_power_osc_enable_o;
	endproperty
	a_osc_sleep: assert property (p_osc_sleep) else $error("oscillator dropped");

	// synchronised mode is frozen in sleep
	property p_sleep_hold;
		@(posedge clk_i) disable iff (rst_i)
		sleep_i && !sync_bypass && !count_write |=> $stable(count);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("counted in sleep");

	// read data equals the count byte at request time
	property p_read_lo;
		@(posedge clk_i) disable iff (rst_i)
		req && !wb_we_i && wb_adr_i == `ADR_CNT_LO |=> wb_dat_o[7:0] == $past(count[7:0]);
	endproperty
	a_read_lo: assert property (p_read_lo) else $error("low byte read wrong");

	// polarity zero holds on high gate
	property p_gate_hold;
		@(posedge clk_i) disable iff (rst_i)
		gate_function_enable && !gate_level_polarity && gate_sig && !count_write
		|=> $stable(count);
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("gate did not hold");

	property p_free_run;
		@(posedge clk_i) disable iff (rst_i)
		counter_run_enable && !gate_function_enable && !sleep_i && edge_bus.tick && !count_write
		&& psc == psc_last(clock_prescale_select) |=> count == $past(count) + 16'h0001;
	endproperty
	a_free_run: assert property (p_free_run) else $error("free run missed");

	property p_run_hold;
		@(posedge clk_i) disable iff (rst_i)
		!counter_run_enable && !count_write |=> $stable(count);
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("stopped timer moved");

	// wrap sets the flag and it stays
	property p_ovf_set;
		@(posedge clk_i) disable iff (rst_i)
		ovf_event |=> count_overflow_flag && count == `COUNT_RESET
		##1 (count_overflow_flag || $past(stat_clear));
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow flag missing");

	property p_closed_hold;
		@(posedge clk_i) disable iff (rst_i)
		!gate_ok && !count_write |=> $stable(count);
	endproperty
	a_closed_hold: assert property (p_closed_hold) else $error("closed gate moved");

	c_overflow: cover property (@(posedge clk_i) disable iff (rst_i) ovf_event);
	c_gated: cover property (@(posedge clk_i) disable iff (rst_i)
		gate_function_enable && !gate_ok && edge_bus.tick);
	c_sleep_wake: cover property (@(posedge clk_i) disable iff (rst_i) wake_o);
	c_bus_write: cover property (@(posedge clk_i) disable iff (rst_i) count_write);
endmodule
`default_nettype wire

// *** pkg/timer_defines.svh ***
// register offsets, field positions and reset values of the gated timer
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
`define ADR_CTRL       8'h00
`define ADR_GATE       8'h04
`define ADR_CNT_LO     8'h08
`define ADR_CNT_HI     8'h0c
`define ADR_IRQ_STAT   8'h10
`define ADR_IRQ_MASK   8'h14
// counter_control fields
`define CTRL_RUN       0
`define CTRL_SYNC_BYP  2
`define CTRL_OSC_EN    3
`define CTRL_PSC_LSB   4
`define CTRL_SRC_BIT   6
`define CTRL_RESET     8'h00
// gate_control fields
`define GATE_SRC_LSB   0
`define GATE_VALUE     2
`define GATE_POL       6
`define GATE_EN        7
`define GATE_RESET     8'h00
// gate source encodings
`define GSRC_PIN       2'h0
`define GSRC_COMPANION 2'h1
`define GSRC_COMPARE   2'h2
// status and mask layout
`define IRQ_OVF        0
`define COUNT_RESET    16'h0000
`define COUNT_MAX      16'hffff
`endif

// *** pkg/timer_pkg.sv ***
// types shared by the gated timer files
package timer_pkg;
	typedef logic [15:0] count_t;
	typedef logic [1:0]  prescale_t;
	typedef logic [1:0]  gate_src_t;
	typedef logic [7:0]  byte_t;
endpackage

// *** pkg/clk_edge_if.sv ***
// carries source choice and the counting edge between front end and core
`timescale 1ns/1ns
`default_nettype none
interface clk_edge_if;
	logic ext_sel;
	logic osc_sel;
	logic bypass;
	logic tick;
	modport front (input ext_sel, input osc_sel, input bypass, output tick);
	modport core  (output ext_sel, output osc_sel, output bypass, input tick);
endinterface
`default_nettype wire

// *** core/clk_front_end.sv ***
// counter clock front end: source pick, optional synchroniser, edge detect
`timescale 1ns/1ns
`default_nettype none
module clk_front_end (
	input  wire logic      clk_i,
	input  wire logic      rst_i,
	input  wire logic      ext_clk_i,
	input  wire logic      crystal_input_pin_i,
	clk_edge_if.front      edge_bus
);
	logic raw;
	logic sync_a;
	logic sync_b;
	logic prev_sync;
	logic prev_raw;
	logic next_tick;

	// crystal pin when the oscillator is on, else the clock pin
	assign raw = edge_bus.osc_sel ? crystal_input_pin_i : ext_clk_i;

	// two-stage synchroniser, first stage read only by the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a    <= 1'b0;
			sync_b    <= 1'b0;
			prev_sync <= 1'b0;
			prev_raw  <= 1'b0;
		end else begin
			sync_a    <= raw;
			sync_b    <= sync_a;
			prev_sync <= sync_b;
			prev_raw  <= raw;
		end
	end

	// mode switch shifts latency by two, may drop or add one edge
	always_comb begin
		next_tick = 1'b1;
		if (edge_bus.ext_sel) begin
			if (edge_bus.bypass) begin
				next_tick = raw & ~prev_raw;
			end else begin
				next_tick = sync_b & ~prev_sync;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			edge_bus.tick <= 1'b0;
		end else begin
			edge_bus.tick <= next_tick;
		end
	end

	// rising edge seen with no sync delay
	property p_bypass_edge;
		@(posedge clk_i) disable iff (rst_i)
		edge_bus.ext_sel && edge_bus.bypass && raw && !prev_raw |=> edge_bus.tick;
	endproperty
	a_bypass_edge: assert property (p_bypass_edge) else $error("bypass edge lost");

	// synchronised edge arrives after the two stages
	property p_sync_edge;
		@(posedge clk_i) disable iff (rst_i)
		edge_bus.ext_sel && !edge_bus.bypass && sync_b && !prev_sync |=> edge_bus.tick;
	endproperty
	a_sync_edge: assert property (p_sync_edge) else $error("sync edge lost");
endmodule
`default_nettype wire

// *** verification/timer_far_side.sv ***
// far side model: external clock pin and low-power crystal driver
`timescale 1ns/1ns
`default_nettype none
module timer_far_side (
	input  wire logic clk_i,
	input  wire logic run_i,
	input  wire logic osc_en_i,
	output logic      ext_clk_o,
	output logic      crystal_o,
	output int        edges_o
);
	int ph = 0;
	initial begin
		ext_clk_o = 1'b0;
		crystal_o = 1'b0;
		edges_o = 0;
	end
	// eight core cycles a period; both lines stand low outside bursts
	// crystal only while enabled
	always @(posedge clk_i) begin
		if (run_i) begin
			ph <= (ph + 1) % 8;
			if (ph == 3) begin
				edges_o <= edges_o + 1;
				if (osc_en_i)
					crystal_o <= 1'b1;
				else
					ext_clk_o <= 1'b1;
			end
			if (ph == 7) begin
				ext_clk_o <= 1'b0;
				crystal_o <= 1'b0;
			end
		end else begin
			ph <= 0;
			ext_clk_o <= 1'b0;
			crystal_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the gated sixteen-bit timer
`timescale 1ns/1ns
`default_nettype none
`include "timer_defines.svh"
module tb_top;
	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             cyc = 1'b0;
	logic             stb = 1'b0;
	logic             we = 1'b0;
	logic [7:0]       adr = 8'h00;
	logic [31:0]      wdat = 32'h0;
	logic [31:0]      rdat;
	logic             ack, osc_en, irq, wake, ext_clk, xtal;
	logic             gpin = 1'b0, covf = 1'b0, cmpo = 1'b0, sleep = 1'b0, run_src = 1'b0;
	int               fail_count = 0;
	int               total_checks = 0;
	int               cyc_n = 0;
	int               edges;
	timer_pkg::byte_t rd, prev;

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) cyc_n <= cyc_n + 1;

	gated_sixteen_bit_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ext_clk_i(ext_clk), .crystal_input_pin_i(xtal), .gate_pin_i(gpin),
		.companion_overflow_i(covf), .comparator_i(cmpo), .sleep_i(sleep),
		.low_power_osc_enable_o(osc_en), .irq_o(irq), .wake_o(wake));
	timer_far_side far_u (.clk_i(clk_i), .run_i(run_src), .osc_en_i(osc_en), .ext_clk_o(ext_clk),
		.crystal_o(xtal), .edges_o(edges));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic miss(input string msg);
		fail_count++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp)
			miss(msg);
	endtask
	task automatic near(input logic [31:0] got, input int lo, input int hi, input string msg);
		total_checks++;
		if ((got >= lo && got <= hi) !== 1'b1)
			miss(msg);
	endtask
	// classic single cycle: hold everything until ack is sampled high
	task automatic wb(input logic [7:0] a, input logic w, input timer_pkg::byte_t d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			miss("no acknowledge");
			print_verdict();
		end
	endtask
	// irq and wake are registered: let two edges land before looking
	task automatic chk_late(input logic got_sel, input logic exp, input string msg);
		repeat (2) @(posedge clk_i);
		chk(got_sel ? wake : irq, exp, msg);
	endtask
	// clears the count (and so the prescaler), runs about forty cycles, reads low byte
	task automatic window(input timer_pkg::byte_t ctrl, output int span);
		int t0;
		wb(`ADR_CNT_LO, 1'b1, 8'h00);
		wb(`ADR_CNT_HI, 1'b1, 8'h00);
		wb(`ADR_CTRL, 1'b1, ctrl | 8'h01);
		t0 = cyc_n;
		repeat (40) @(posedge clk_i);
		wb(`ADR_CTRL, 1'b1, ctrl);
		span = cyc_n - t0;
		wb(`ADR_CNT_LO, 1'b0, 8'h00);
	endtask

	initial begin
		int span, e0, open;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values of every register, plus one unmapped place
		for (int i = 0; i < 7; i++) begin
			wb(8'(i * 4), 1'b0, 8'h00);
			chk(rd, 8'h00, "reset or unmapped read");
		end
		// each prescale setting, then the held value after stopping
		for (int p = 0; p < 4; p++) begin
			window(8'(p << 4), span);
			near(rd, (span >> p) - 1, (span >> p) + 1, "prescaled count");
			prev = rd;
			repeat (10) @(posedge clk_i);
			wb(`ADR_CNT_LO, 1'b0, 8'h00);
			chk(rd, prev, "count moved while stopped");
		end
		// g bit0 level, bit1 polarity, bits 3:2 source; unselected sources disagree
		for (int g = 0; g < 16; g++) begin
			gpin <= (g[3:2] == 2'h0) ? g[0] : !g[0];
			covf <= (g[3:2] == 2'h1) ? g[0] : !g[0];
			cmpo <= (g[3:2] == 2'h2) ? g[0] : !g[0];
			wb(`ADR_GATE, 1'b1, {1'b1, g[1], 4'h0, g[3:2]});
			open = (g[3:2] == 2'h3) ? !g[1] : (g[0] == g[1]);
			window(8'h00, span);
			if (open)
				near(rd, span - 1, span + 1, "gate open");
			else
				chk(rd, 8'h00, "gate closed");
		end
		wb(`ADR_GATE, 1'b1, 8'h00);
		window(8'h00, span);
		near(rd, span - 1, span + 1, "gate off must count");
		// crystal start-up check: stopped preset fc00, await flag after 1024 counts
		wb(`ADR_IRQ_MASK, 1'b1, 8'h01);
		wb(`ADR_IRQ_STAT, 1'b1, 8'h01);
		wb(`ADR_CNT_LO, 1'b1, 8'h00);
		wb(`ADR_CNT_HI, 1'b1, 8'hfc);
		wb(`ADR_CTRL, 1'b1, 8'h48);
		chk_late(1'b0, 1'b0, "irq before overflow");
		chk(osc_en, 1'b1, "oscillator enable");
		wb(`ADR_CTRL, 1'b1, 8'h49);
		e0 = edges;
		run_src <= 1'b1;
		for (int n = 0; n < 9000 && irq !== 1'b1; n++)
			@(posedge clk_i);
		run_src <= 1'b0;
		near(edges - e0, 1023, 1027, "edges to overflow");
		wb(`ADR_CTRL, 1'b1, 8'h40);
		// the enable output is registered: it follows the write one edge later
		repeat (2) @(posedge clk_i);
		chk(osc_en, 1'b0, "oscillator disable");
		wb(`ADR_IRQ_STAT, 1'b0, 8'h00);
		chk(rd, 8'h01, "sticky flag");
		wb(`ADR_IRQ_MASK, 1'b1, 8'h00);
		chk_late(1'b0, 1'b0, "masked irq");
		wb(`ADR_IRQ_MASK, 1'b1, 8'h01);
		chk_late(1'b0, 1'b1, "unmasked irq");
		wb(`ADR_IRQ_STAT, 1'b1, 8'h01);
		chk_late(1'b0, 1'b0, "cleared irq");
		// bypass mode on the crystal keeps counting in sleep, overflow wakes the core
		wb(`ADR_CTRL, 1'b1, 8'h4c);
		wb(`ADR_CNT_LO, 1'b1, 8'hf0);
		wb(`ADR_CNT_HI, 1'b1, 8'hff);
		sleep <= 1'b1;
		wb(`ADR_CTRL, 1'b1, 8'h4d);
		e0 = edges;
		run_src <= 1'b1;
		for (int n = 0; n < 400 && edges - e0 < 20; n++)
			@(posedge clk_i);
		run_src <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk(wake, 1'b1, "wake in sleep");
		chk(osc_en, 1'b1, "oscillator in sleep");
		sleep <= 1'b0;
		chk_late(1'b1, 1'b0, "wake after sleep");
		wb(`ADR_CTRL, 1'b1, 8'h4c);
		wb(`ADR_CNT_LO, 1'b0, 8'h00);
		chk(rd, 8'h04, "async low byte");
		wb(`ADR_CNT_HI, 1'b0, 8'h00);
		chk(rd, 8'h00, "async high byte");
		// synchronised counting must freeze while asleep; stop before waking
		sleep <= 1'b1;
		wb(`ADR_CTRL, 1'b1, 8'h49);
		run_src <= 1'b1;
		repeat (80) @(posedge clk_i);
		run_src <= 1'b0;
		wb(`ADR_CTRL, 1'b1, 8'h48);
		sleep <= 1'b0;
		wb(`ADR_CNT_LO, 1'b0, 8'h00);
		chk(rd, 8'h04, "counted in sleep");
		print_verdict();
	end
endmodule
`default_nettype wire
